// File: hdl/reference_oscillator_select.v
// Reference source selection, calibration slots and frequency override.
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "ref_osc_consts.vh"
// What this block does
// - Host picks onboard crystal or backplane slot.
// - Ten retained calibration slots for backplane sources.
// - Alias selects the same source as slot one.
// - Uncalibrated selection warns and uses ideal 10 MHz.
// - Override accepts restore or 9 to 11 MHz.
// - Source change discards any override.
// - Restore reloads calibration, else 10 MHz.
// - Readback reports frequency currently in effect.
// - Counter clock follows selection; absent backplane latches fault.
module reference_oscillator_select
(
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        onboard_ref,
	input  wire        backplane_ref,
	input  wire        backplane_present,
	output reg         counter_ref,
	output reg         use_backplane,
	output reg         counter_fault,
	output reg         irq
);

	// ****************************************************************
	// State
	// ****************************************************************
	reg [3:0]  source_sel;
	reg [31:0] freq_in_effect;
	reg [31:0] cal_value [0:`ROS_NUM_SLOTS-1];
	reg [`ROS_NUM_SLOTS-1:0] cal_valid;
	reg [3:0]  cal_slot;
	reg [2:0]  status;
	reg [2:0]  mask;
	reg [7:0]  wr_addr;
	reg [31:0] wr_data;
	reg        have_aw;
	reg        have_w;
	reg        wr_strb_ok;

	wire [3:0] slot_of_sel = (source_sel == `ROS_SRC_ALIAS) ? 4'h0 : source_sel - 4'h1;
	wire       wr_go = have_aw && have_w && !s_axi_bvalid;
	// An empty strobe refuses the write, so nothing below may act on it.
	wire       wr_do = wr_go && wr_strb_ok;
	wire       wsel = wr_do && (wr_addr == `ROS_OFF_SELECT);
	wire       wfreq = wr_do && (wr_addr == `ROS_OFF_FREQ_SET);
	wire       wslot = wr_do && (wr_addr == `ROS_OFF_CAL_SLOT);
	wire       wcal = wr_do && (wr_addr == `ROS_OFF_CAL_DATA);
	wire       wmask = wr_do && (wr_addr == `ROS_OFF_MASK);
	wire       wctrl = wr_do && (wr_addr == `ROS_OFF_CTRL);
	wire       wmap = wsel | wfreq | wslot | wcal | wmask | wctrl |
		(wr_do && (wr_addr == `ROS_OFF_FREQ_READ)) |
		(wr_do && (wr_addr == `ROS_OFF_STATUS));
	wire [3:0] new_sel = wr_data[3:0];
	wire       sel_ok = (new_sel <= `ROS_SRC_ALIAS);
	wire [3:0] new_slot = (new_sel == `ROS_SRC_ALIAS) ? 4'h0 : new_sel - 4'h1;
	wire       new_onboard = (new_sel == `ROS_SRC_ONBOARD);
	wire       freq_ok = (wr_data >= `ROS_FREQ_MIN) && (wr_data <= `ROS_FREQ_MAX);
	wire       restore = wr_data[`ROS_RESTORE_BIT];
	wire       sel_onboard = (source_sel == `ROS_SRC_ONBOARD);
	reg  [31:0] stored_now;
	reg  [31:0] stored_new;
	reg  [2:0]  next_status;
	reg  [31:0] rd_mux;
	reg         rd_map;

	always @*
	begin
		stored_now = `ROS_FREQ_IDEAL;
		if (sel_onboard)
			stored_now = `ROS_ONBOARD_CAL;
		else if (cal_valid[slot_of_sel])
			stored_now = cal_value[slot_of_sel];
		stored_new = `ROS_FREQ_IDEAL;
		if (new_onboard)
			stored_new = `ROS_ONBOARD_CAL;
		else if (cal_valid[new_slot])
			stored_new = cal_value[new_slot];
	end

	// ****************************************************************
	// Selection, override and frequency in effect
	// ****************************************************************
	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			source_sel <= `ROS_SRC_ONBOARD;
			freq_in_effect <= `ROS_ONBOARD_CAL;
			cal_slot <= 4'h0;
			mask <= 3'h0;
		end
		else
		begin
			if (wsel && sel_ok)
			begin
				source_sel <= new_sel;
				freq_in_effect <= stored_new;
			end
			else if (wfreq && restore)
				freq_in_effect <= stored_now;
			else if (wfreq && freq_ok)
				freq_in_effect <= wr_data;
			else if (wcal && !sel_onboard && (cal_slot == slot_of_sel))
				freq_in_effect <= wr_data;
			if (wslot && (wr_data[3:0] < `ROS_NUM_SLOTS))
				cal_slot <= wr_data[3:0];
			if (wmask)
				mask <= wr_data[2:0];
		end
	end

	// Calibration slots have no reset so they survive instrument reset; retention across
	// power cycles relies on the storage cells beneath them.
	genvar gi;
	generate
		for (gi = 0; gi < `ROS_NUM_SLOTS; gi = gi + 1)
		begin : g_slot
			always @(posedge core_clk)
			begin
				if (wcal && (cal_slot == gi))
					cal_value[gi] <= wr_data;
			end
			always @(posedge core_clk)
			begin
				if (wctrl && wr_data[0] && (cal_slot == gi))
					cal_valid[gi] <= 1'b0;
				else if (wcal && (cal_slot == gi))
					cal_valid[gi] <= 1'b1;
			end
		end
	endgenerate

	// ****************************************************************
	// Status and interrupt
	// ****************************************************************
	wire rd_go = s_axi_arvalid && s_axi_arready;
	wire rd_status = rd_go && (s_axi_araddr == `ROS_OFF_STATUS);

	always @*
	begin
		next_status = status;
		if (rd_status)
			next_status = 3'h0;
		if (wsel && sel_ok && !new_onboard && !cal_valid[new_slot])
			next_status[`ROS_ST_NOTCAL] = 1'b1;
		if (wfreq && !restore && !freq_ok)
			next_status[`ROS_ST_BADFREQ] = 1'b1;
		if (wsel && !sel_ok)
			next_status[`ROS_ST_BADSEL] = 1'b1;
	end

	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			status <= 3'h0;
			irq <= 1'b0;
		end
		else
		begin
			status <= next_status;
			irq <= |(next_status & mask);
		end
	end

	// ****************************************************************
	// Reference routing
	// ****************************************************************
	// The output is retimed on core_clk, so it is a sampled copy of the chosen reference.
	// The fault is sticky past reset because only a power cycle clears it.
	initial counter_fault = 1'b0;
	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			counter_ref <= 1'b0;
			use_backplane <= 1'b0;
		end
		else
		begin
			use_backplane <= !sel_onboard;
			counter_ref <= sel_onboard ? onboard_ref : backplane_ref;
		end
		if (!sel_onboard && !backplane_present)
			counter_fault <= 1'b1;
	end

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	// Software is expected to change source only while the counter is idle.
	always @*
	begin
		rd_map = 1'b1;
		case (s_axi_araddr)
			`ROS_OFF_SELECT:            rd_mux = {28'h0, source_sel};
			`ROS_OFF_FREQ_SET:          rd_mux = freq_in_effect;
			`ROS_OFF_FREQ_READ:         rd_mux = freq_in_effect;
			`ROS_OFF_CAL_SLOT:          rd_mux = {28'h0, cal_slot};
			`ROS_OFF_CAL_DATA:          rd_mux = cal_value[cal_slot];
			`ROS_OFF_STATUS:            rd_mux = {29'h0, status};
			`ROS_OFF_MASK:              rd_mux = {29'h0, mask};
			`ROS_OFF_CTRL:              rd_mux = {22'h0, cal_valid};
			default:
			begin
				rd_mux = 32'h0;
				rd_map = 1'b0;
			end
		endcase
	end

	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ROS_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `ROS_RESP_OKAY;
			have_aw <= 1'b0;
			have_w <= 1'b0;
			wr_addr <= 8'h0;
			wr_data <= 32'h0;
			wr_strb_ok <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !have_aw && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !have_w && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				have_aw <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				have_w <= 1'b1;
				wr_data <= s_axi_wdata;
				// The strobe is only valid with its data, so it is kept with it.
				wr_strb_ok <= (s_axi_wstrb != 4'h0);
			end
			if (wr_go)
			begin
				have_aw <= 1'b0;
				have_w <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wmap ? `ROS_RESP_OKAY : `ROS_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_map ? `ROS_RESP_OKAY : `ROS_RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// File: shared/ref_osc_consts.vh
// Constants for the reference oscillator select block.
`ifndef REF_OSC_CONSTS_VH
`define REF_OSC_CONSTS_VH
`define ROS_OFF_SELECT     8'h00
`define ROS_OFF_FREQ_SET   8'h04
`define ROS_OFF_FREQ_READ  8'h08
`define ROS_OFF_CAL_SLOT   8'h0C
`define ROS_OFF_CAL_DATA   8'h10
`define ROS_OFF_STATUS     8'h14
`define ROS_OFF_MASK       8'h18
`define ROS_OFF_CTRL       8'h1C
`define ROS_SRC_ONBOARD    4'h0
`define ROS_SRC_ALIAS      4'hB
`define ROS_NUM_SLOTS      10
`define ROS_FREQ_IDEAL     32'h00989680
`define ROS_FREQ_MIN       32'h00895440
`define ROS_FREQ_MAX       32'h00A7D8C0
`define ROS_RESTORE_BIT    31
`define ROS_ST_NOTCAL      0
`define ROS_ST_BADFREQ     1
`define ROS_ST_BADSEL      2
`define ROS_ONBOARD_CAL    32'h00989680
`define ROS_RESP_OKAY      2'h0
`define ROS_RESP_SLVERR    2'h2
`endif

// File: tb/backplane_ref_model.sv
// Backplane reference line as seen by the oscillator select block.
`timescale 1ns/10ps
module backplane_ref_model
(
	input  wire logic enable,
	output logic      ref_clk,
	output logic      present
);
	initial ref_clk = 1'b0;
	assign present = enable;
	// An absent source is a steady toggle every 30 ns, never a frozen level a copy could fake.
	// An unknown enable at time zero counts as present, so the delay is never zero.
	always #((enable === 1'b0) ? 30 : 50) ref_clk = ~ref_clk;
endmodule

// File: tb/ref_osc_monitor.sv
// Port checker for the reference oscillator select block.
`timescale 1ns/10ps
module ref_osc_monitor
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic onboard_ref,
	input wire logic backplane_ref,
	input wire logic backplane_present,
	input wire logic counter_ref,
	input wire logic use_backplane,
	input wire logic counter_fault,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_bdone: assert property (p_bdone) else $error("bvalid held");
	property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_rdone: assert property (p_rdone) else $error("rvalid held");
	property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rlat: assert property (p_rlat) else $error("read late");
	property p_flt; use_backplane && !backplane_present |-> ##[0:3] counter_fault; endproperty
	a_flt: assert property (p_flt) else $error("no fault");
	property p_keep; counter_fault |=> counter_fault; endproperty
	a_keep: assert property (p_keep) else $error("fault lost");
	property p_bp; (use_backplane && rst_n)[*3] |-> counter_ref == $past(backplane_ref); endproperty
	a_bp: assert property (p_bp) else $error("bad backplane ref");
	property p_ob; (!use_backplane && rst_n)[*3] |-> counter_ref == $past(onboard_ref); endproperty
	a_ob: assert property (p_ob) else $error("bad onboard ref");
	property p_rst; $rose(rst_n) |-> !use_backplane && !irq && !s_axi_rvalid; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	cover property (counter_fault);
	cover property (irq);
	cover property (use_backplane && s_axi_rvalid);
endmodule
bind reference_oscillator_select ref_osc_monitor i_ref_osc_monitor (.core_clk, .rst_n,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.onboard_ref, .backplane_ref, .backplane_present, .counter_ref, .use_backplane,
	.counter_fault, .irq);

// File: tb/testbench.sv
// Self-checking bench for the reference oscillator select block.
`timescale 1ns/10ps
`include "ref_osc_consts.vh"
module testbench;
	logic        core_clk, rst_n, onboard_ref, bp_on;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire         backplane_ref, backplane_present, counter_ref, use_backplane, counter_fault, irq;
	int          n_fail, tests_run, n;
	reference_oscillator_select i_reference_oscillator_select (.core_clk, .rst_n,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .onboard_ref,
		.backplane_ref, .backplane_present, .counter_ref, .use_backplane, .counter_fault, .irq);
	backplane_ref_model i_backplane_ref_model (.enable(bp_on), .ref_clk(backplane_ref),
		.present(backplane_present));
	initial
	begin
		core_clk = 1'h0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) onboard_ref <= ~onboard_ref;
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tmo;
		if (n >= 40)
		begin
			n_fail++;
			wrap_up;
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) s_axi_bready <= 1'h0;
			if (s_axi_bvalid) chk("bresp", er, s_axi_bresp);
		end
		while (s_axi_bready && n < 40);
		tmo;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] er);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) s_axi_rready <= 1'h0;
			if (s_axi_rvalid) chk("rdata", e, s_axi_rdata);
			if (s_axi_rvalid) chk("rresp", er, s_axi_rresp);
		end
		while (s_axi_rready && n < 40);
		tmo;
	endtask
	// The fault flag is meant to survive this, so only a fresh run clears it.
	task automatic rst;
		rst_n <= 1'h0;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'h1;
		@(posedge core_clk);
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_cal;
		rd(`ROS_OFF_SELECT, 32'h0, 2'h0);
		rd(`ROS_OFF_FREQ_READ, `ROS_ONBOARD_CAL, 2'h0);
		wr(`ROS_OFF_CAL_SLOT, 32'h1, 2'h0);
		wr(`ROS_OFF_CTRL, 32'h1, 2'h0);
		wr(`ROS_OFF_CAL_SLOT, 32'h0, 2'h0);
		wr(`ROS_OFF_CAL_DATA, 32'h989681, 2'h0);
		wr(`ROS_OFF_SELECT, {28'h0, `ROS_SRC_ALIAS}, 2'h0);
		rd(`ROS_OFF_SELECT, {28'h0, `ROS_SRC_ALIAS}, 2'h0);
		rd(`ROS_OFF_FREQ_READ, 32'h989681, 2'h0);
		chk("use_backplane", 32'h1, use_backplane);
		rd(`ROS_OFF_STATUS, 32'h0, 2'h0);
		wr(`ROS_OFF_SELECT, 32'h2, 2'h0);
		rd(`ROS_OFF_FREQ_READ, `ROS_FREQ_IDEAL, 2'h0);
		rd(`ROS_OFF_STATUS, 32'h1, 2'h0);
		$display("test cal done");
	endtask
	task automatic t_ovr;
		wr(`ROS_OFF_FREQ_SET, `ROS_FREQ_MIN, 2'h0);
		wr(`ROS_OFF_FREQ_SET, `ROS_FREQ_MAX + 32'h1, 2'h0);
		rd(`ROS_OFF_FREQ_SET, `ROS_FREQ_MIN, 2'h0);
		rd(`ROS_OFF_STATUS, 32'h2, 2'h0);
		wr(`ROS_OFF_FREQ_SET, 32'h80000000, 2'h0);
		rd(`ROS_OFF_FREQ_READ, `ROS_FREQ_IDEAL, 2'h0);
		wr(`ROS_OFF_FREQ_SET, `ROS_FREQ_MAX, 2'h0);
		rd(`ROS_OFF_FREQ_READ, `ROS_FREQ_MAX, 2'h0);
		wr(`ROS_OFF_SELECT, 32'h1, 2'h0);
		rd(`ROS_OFF_FREQ_READ, 32'h989681, 2'h0);
		wr(`ROS_OFF_CAL_DATA, 32'h989682, 2'h0);
		rd(`ROS_OFF_FREQ_READ, 32'h989682, 2'h0);
		wr(`ROS_OFF_CAL_SLOT, 32'hA, 2'h0);
		rd(`ROS_OFF_CAL_SLOT, 32'h0, 2'h0);
		rd(`ROS_OFF_CAL_DATA, 32'h989682, 2'h0);
		$display("test override done");
	endtask
	task automatic t_irq;
		wr(`ROS_OFF_MASK, 32'h7, 2'h0);
		wr(`ROS_OFF_SELECT, 32'hC, 2'h0);
		chk("irq", 32'h1, irq);
		rd(`ROS_OFF_STATUS, 32'h4, 2'h0);
		chk("irq", 32'h0, irq);
		wr(`ROS_OFF_MASK, 32'h3, 2'h0);
		wr(`ROS_OFF_SELECT, 32'hC, 2'h0);
		chk("irq", 32'h0, irq);
		s_axi_wstrb <= 4'h0;
		wr(`ROS_OFF_SELECT, 32'h0, `ROS_RESP_SLVERR);
		s_axi_wstrb <= 4'hF;
		rd(`ROS_OFF_SELECT, 32'h1, 2'h0);
		wr(8'h20, 32'h5, `ROS_RESP_SLVERR);
		rd(8'h20, 32'h0, `ROS_RESP_SLVERR);
		$display("test irq done");
	endtask
	task automatic t_fault;
		chk("counter_fault", 32'h0, counter_fault);
		bp_on <= 1'h0;
		wr(`ROS_OFF_SELECT, 32'h1, 2'h0);
		for (n = 0; n < 40 && counter_fault !== 1'h1; n++) @(posedge core_clk);
		chk("counter_fault", 32'h1, counter_fault);
		rst;
		chk("counter_fault", 32'h1, counter_fault);
		chk("use_backplane", 32'h0, use_backplane);
		$display("test fault done");
	endtask
	initial
	begin
		{rst_n, onboard_ref, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
		s_axi_wstrb = 4'hF;
		bp_on = 1'h1;
		rst;
		t_cal;
		t_ovr;
		t_irq;
		t_fault;
		wrap_up;
	end
endmodule
